// ---- hw/cod_core.v ----
// cpu slice core: fetch, address sequencing, execute and stack pushes
`timescale 1ns/1ps
`include "cod_defines.vh"

module cod_core (
    // clock and reset
    input wire clk,
    input wire rstn,
    // memory bus
    output wire [15:0] memAddr,
    input wire [7:0] memRdata,
    output wire [7:0] memWdata,
    output wire memWe,
    // instruction progress
    output wire instrStart,
    output wire illegalOp,
    output wire [3:0] lastCycles,
    // architectural state
    output wire [15:0] pcOut,
    output wire [7:0] accOut,
    output wire [7:0] xOut,
    output wire [7:0] yOut,
    output wire [7:0] spOut,
    output wire [7:0] statusOut
);

localparam [3:0] S_FETCH = 4'h0;
localparam [3:0] S_T1 = 4'h1;
localparam [3:0] S_ZPADD = 4'h2;
localparam [3:0] S_PTRLO = 4'h3;
localparam [3:0] S_PTRHI = 4'h4;
localparam [3:0] S_ADH = 4'h5;
localparam [3:0] S_FIX = 4'h6;
localparam [3:0] S_READ = 4'h7;
localparam [3:0] S_RMW1 = 4'h8;
localparam [3:0] S_RMW2 = 4'h9;
localparam [3:0] S_PUSH = 4'hA;
localparam [3:0] S_CALL0 = 4'hB;
localparam [3:0] S_CALLH = 4'hC;
localparam [3:0] S_CALLL = 4'hD;
localparam [3:0] S_JLO = 4'hE;
localparam [3:0] S_JHI = 4'hF;

// classes that set negative and zero from the result
function setsNz;
    input [3:0] cls;
    begin
        case (cls)
            `COD_C_XOR, `COD_C_OR, `COD_C_LOADA, `COD_C_LOADX, `COD_C_LOADY,
            `COD_C_INCM, `COD_C_INCX, `COD_C_INCY, `COD_C_SHR: setsNz = 1'b1;
            default: setsNz = 1'b0;
        endcase
    end
endfunction

// stack slot address inside page one
function [15:0] stackAddr;
    input [7:0] sp;
    begin
        stackAddr = {`COD_STACK_PAGE, sp};
    end
endfunction

reg [3:0] state_r, state_nxt;
reg [15:0] pc_r, pc_nxt;
reg [7:0] a_r, a_nxt;
reg [7:0] x_r, x_nxt;
reg [7:0] y_r, y_nxt;
reg [7:0] sp_r, sp_nxt;
reg n_r, n_nxt;
reg z_r, z_nxt;
reg c_r, c_nxt;
reg [7:0] op_r, op_nxt;
reg [7:0] adl_r, adl_nxt;
reg [7:0] adh_r, adh_nxt;
reg [7:0] dat_r, dat_nxt;
reg [15:0] memAddr_r, memAddr_nxt;
reg [7:0] memWdata_r, memWdata_nxt;
reg memWe_r, memWe_nxt;
reg illegal_r;
reg instrStart_r;
reg [3:0] cyc_r;
reg [3:0] lastCycles_r, lastCycles_nxt;
reg execEn;
reg doIdx;
reg [8:0] idxSum;
reg [7:0] zpSum;

wire [3:0] opClass;
wire [3:0] addrMode;
wire idxY;
wire legal;
wire [7:0] aluRes;
wire aluN;
wire aluZ;
wire aluC;
wire [7:0] idxVal;
wire rmw;
wire [7:0] statusByte;

cod_decode u_dec (
    .opcode(op_r),
    .opClass(opClass),
    .addrMode(addrMode),
    .idxY(idxY),
    .legal(legal)
);

cod_alu u_alu (
    .opClass(opClass),
    .accMode(addrMode == `COD_M_ACC),
    .accIn(a_r),
    .xIn(x_r),
    .yIn(y_r),
    .memIn(memRdata),
    .result(aluRes),
    .negOut(aluN),
    .zeroOut(aluZ),
    .carryOut(aluC)
);

assign idxVal = idxY ? y_r : x_r;
assign rmw = (opClass == `COD_C_INCM) ||
             ((opClass == `COD_C_SHR) && (addrMode != `COD_M_ACC));
// overflow, decimal and interrupt-disable are never touched by this slice
assign statusByte = {n_r, `COD_V_RST, 1'b1, 1'b1, `COD_D_RST, `COD_I_RST, z_r, c_r};

always @* begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    a_nxt = a_r;
    x_nxt = x_r;
    y_nxt = y_r;
    sp_nxt = sp_r;
    n_nxt = n_r;
    z_nxt = z_r;
    c_nxt = c_r;
    op_nxt = op_r;
    adl_nxt = adl_r;
    adh_nxt = adh_r;
    dat_nxt = dat_r;
    memAddr_nxt = memAddr_r;
    memWdata_nxt = memWdata_r;
    memWe_nxt = 1'b0;
    execEn = 1'b0;
    doIdx = 1'b0;
    idxSum = {1'b0, adl_r} + {1'b0, idxVal};
    zpSum = adl_r + idxVal;
    case (state_r)
        S_FETCH: begin
            op_nxt = memRdata;
            pc_nxt = pc_r + 16'h0001;
            memAddr_nxt = pc_r + 16'h0001;
            state_nxt = S_T1;
        end
        S_T1: begin
            case (addrMode)
                `COD_M_IMP, `COD_M_ACC: begin
                    // dummy read of the next byte; counter stays put
                    memAddr_nxt = pc_r;
                    state_nxt = S_FETCH;
                    if ((opClass == `COD_C_PUSHA) || (opClass == `COD_C_PUSHP)) begin
                        memAddr_nxt = stackAddr(sp_r);
                        memWe_nxt = 1'b1;
                        if (opClass == `COD_C_PUSHA) begin
                            memWdata_nxt = a_r;
                        end else begin
                            memWdata_nxt = statusByte;
                        end
                        state_nxt = S_PUSH;
                    end else begin
                        execEn = 1'b1;
                    end
                end
                `COD_M_IMM: begin
                    execEn = 1'b1;
                    pc_nxt = pc_r + 16'h0001;
                    memAddr_nxt = pc_r + 16'h0001;
                    state_nxt = S_FETCH;
                end
                `COD_M_ZP: begin
                    adl_nxt = memRdata;
                    pc_nxt = pc_r + 16'h0001;
                    memAddr_nxt = {`COD_ZERO_PAGE, memRdata};
                    state_nxt = S_READ;
                end
                `COD_M_ZPI, `COD_M_INDX, `COD_M_INDY: begin
                    adl_nxt = memRdata;
                    pc_nxt = pc_r + 16'h0001;
                    memAddr_nxt = {`COD_ZERO_PAGE, memRdata};
                    state_nxt = (addrMode == `COD_M_INDY) ? S_PTRLO : S_ZPADD;
                end
                default: begin
                    adl_nxt = memRdata;
                    pc_nxt = pc_r + 16'h0001;
                    memAddr_nxt = pc_r + 16'h0001;
                    state_nxt = S_ADH;
                    if (opClass == `COD_C_CALL) begin
                        memAddr_nxt = stackAddr(sp_r);
                        state_nxt = S_CALL0;
                    end
                end
            endcase
        end
        S_ZPADD: begin
            // zero page indexing wraps inside page zero
            adl_nxt = zpSum;
            memAddr_nxt = {`COD_ZERO_PAGE, zpSum};
            state_nxt = (addrMode == `COD_M_INDX) ? S_PTRLO : S_READ;
        end
        S_PTRLO: begin
            adl_nxt = memRdata;
            memAddr_nxt = {`COD_ZERO_PAGE, adl_r + 8'h01};
            state_nxt = S_PTRHI;
        end
        S_PTRHI: begin
            adh_nxt = memRdata;
            memAddr_nxt = {memRdata, adl_r};
            state_nxt = S_READ;
            doIdx = (addrMode == `COD_M_INDY);
        end
        S_ADH: begin
            adh_nxt = memRdata;
            memAddr_nxt = {memRdata, adl_r};
            state_nxt = S_READ;
            if (opClass == `COD_C_JUMP && addrMode == `COD_M_IND) begin
                state_nxt = S_JLO;
            end else if (opClass == `COD_C_JUMP || opClass == `COD_C_CALL) begin
                pc_nxt = {memRdata, adl_r};
                state_nxt = S_FETCH;
            end else begin
                pc_nxt = pc_r + 16'h0001;
                doIdx = (addrMode == `COD_M_ABSI);
            end
        end
        S_FIX: begin
            memAddr_nxt = {adh_r, adl_r};
            state_nxt = S_READ;
        end
        S_READ: begin
            execEn = 1'b1;
            if (rmw) begin
                // old value goes back out first, the new one a cycle later
                dat_nxt = aluRes;
                memWe_nxt = 1'b1;
                memWdata_nxt = memRdata;
                state_nxt = S_RMW1;
            end else begin
                memAddr_nxt = pc_r;
                state_nxt = S_FETCH;
            end
        end
        S_RMW1: begin
            memWe_nxt = 1'b1;
            memWdata_nxt = dat_r;
            state_nxt = S_RMW2;
        end
        S_RMW2: begin
            memAddr_nxt = pc_r;
            state_nxt = S_FETCH;
        end
        S_PUSH: begin
            sp_nxt = sp_r - 8'h01;
            memAddr_nxt = pc_r;
            state_nxt = S_FETCH;
        end
        S_CALL0: begin
            memWe_nxt = 1'b1;
            memWdata_nxt = pc_r[15:8];
            memAddr_nxt = stackAddr(sp_r);
            state_nxt = S_CALLH;
        end
        S_CALLH: begin
            sp_nxt = sp_r - 8'h01;
            memWe_nxt = 1'b1;
            memWdata_nxt = pc_r[7:0];
            memAddr_nxt = stackAddr(sp_r - 8'h01);
            state_nxt = S_CALLL;
        end
        S_CALLL: begin
            sp_nxt = sp_r - 8'h01;
            memAddr_nxt = pc_r;
            state_nxt = S_ADH;
        end
        S_JLO: begin
            dat_nxt = memRdata;
            memAddr_nxt = {adh_r, adl_r} + 16'h0001;
            state_nxt = S_JHI;
        end
        S_JHI: begin
            pc_nxt = {memRdata, dat_r};
            memAddr_nxt = {memRdata, dat_r};
            state_nxt = S_FETCH;
        end
        default: begin
            memAddr_nxt = pc_r;
            state_nxt = S_FETCH;
        end
    endcase
    // a carry out of the low byte costs a fix-up cycle; writes always take it
    if (doIdx) begin
        adl_nxt = idxSum[7:0];
        memAddr_nxt = {memRdata, idxSum[7:0]};
        if (idxSum[8] || rmw) begin
            adh_nxt = memRdata + {7'h00, idxSum[8]};
            state_nxt = S_FIX;
        end
    end
    if (execEn) begin
        case (opClass)
            `COD_C_XOR, `COD_C_OR, `COD_C_LOADA: a_nxt = aluRes;
            `COD_C_SHR: a_nxt = (addrMode == `COD_M_ACC) ? aluRes : a_r;
            `COD_C_LOADX, `COD_C_INCX: x_nxt = aluRes;
            `COD_C_LOADY, `COD_C_INCY: y_nxt = aluRes;
            default: a_nxt = a_r;
        endcase
        if (setsNz(opClass)) begin
            n_nxt = aluN;
            z_nxt = aluZ;
        end
        if (opClass == `COD_C_SHR) begin
            c_nxt = aluC;
        end
    end
    lastCycles_nxt = (state_nxt == S_FETCH) ? cyc_r : lastCycles_r;
end

always @(posedge clk) begin
    if (!rstn) begin
        state_r <= S_FETCH;
        pc_r <= `COD_PC_RST;
        a_r <= `COD_A_RST;
        x_r <= `COD_A_RST;
        y_r <= `COD_A_RST;
        sp_r <= `COD_SP_RST;
        n_r <= 1'b0;
        z_r <= 1'b0;
        c_r <= 1'b0;
        op_r <= 8'h00;
        adl_r <= 8'h00;
        adh_r <= 8'h00;
        dat_r <= 8'h00;
        memAddr_r <= `COD_PC_RST;
        memWdata_r <= 8'h00;
        memWe_r <= 1'b0;
        illegal_r <= 1'b0;
        instrStart_r <= 1'b1;
        cyc_r <= 4'h1;
        lastCycles_r <= 4'h0;
    end else begin
        state_r <= state_nxt;
        pc_r <= pc_nxt;
        a_r <= a_nxt;
        x_r <= x_nxt;
        y_r <= y_nxt;
        sp_r <= sp_nxt;
        n_r <= n_nxt;
        z_r <= z_nxt;
        c_r <= c_nxt;
        op_r <= op_nxt;
        adl_r <= adl_nxt;
        adh_r <= adh_nxt;
        dat_r <= dat_nxt;
        memAddr_r <= memAddr_nxt;
        memWdata_r <= memWdata_nxt;
        memWe_r <= memWe_nxt;
        illegal_r <= (state_r == S_T1) && !legal;
        instrStart_r <= (state_nxt == S_FETCH);
        cyc_r <= (state_nxt == S_FETCH) ? 4'h1 : cyc_r + 4'h1;
        lastCycles_r <= lastCycles_nxt;
    end
end

assign memAddr = memAddr_r;
assign memWdata = memWdata_r;
assign memWe = memWe_r;
assign instrStart = instrStart_r;
assign illegalOp = illegal_r;
assign lastCycles = lastCycles_r;
assign pcOut = pc_r;
assign accOut = a_r;
assign xOut = x_r;
assign yOut = y_r;
assign spOut = sp_r;
assign statusOut = statusByte;

endmodule // cod_core

// ---- pkg/cod_defines.vh ----
// shared constants for the cpu opcode slice: classes, modes, flags, reset values
`ifndef COD_DEFINES_VH
`define COD_DEFINES_VH

// operation classes
`define COD_C_IDLE 4'h0
`define COD_C_XOR 4'h1
`define COD_C_OR 4'h2
`define COD_C_LOADA 4'h3
`define COD_C_LOADX 4'h4
`define COD_C_LOADY 4'h5
`define COD_C_INCM 4'h6
`define COD_C_INCX 4'h7
`define COD_C_INCY 4'h8
`define COD_C_SHR 4'h9
`define COD_C_JUMP 4'hA
`define COD_C_CALL 4'hB
`define COD_C_PUSHA 4'hC
`define COD_C_PUSHP 4'hD

// addressing modes
`define COD_M_IMP 4'h0
`define COD_M_ACC 4'h1
`define COD_M_IMM 4'h2
`define COD_M_ZP 4'h3
`define COD_M_ZPI 4'h4
`define COD_M_ABS 4'h5
`define COD_M_ABSI 4'h6
`define COD_M_IND 4'h7
`define COD_M_INDX 4'h8
`define COD_M_INDY 4'h9

// status byte bit positions
`define COD_SB_N 7
`define COD_SB_V 6
`define COD_SB_U 5
`define COD_SB_B 4
`define COD_SB_D 3
`define COD_SB_I 2
`define COD_SB_Z 1
`define COD_SB_C 0

// memory pages
`define COD_ZERO_PAGE 8'h00
`define COD_STACK_PAGE 8'h01

// reset values
`define COD_PC_RST 16'h0000
`define COD_SP_RST 8'hFF
`define COD_A_RST 8'h00
`define COD_V_RST 1'b0
`define COD_D_RST 1'b0
`define COD_I_RST 1'b1

`endif

// ---- hw/cod_decode.v ----
// opcode decoder: class, addressing mode, index choice and legality
`timescale 1ns/1ps
`include "cod_defines.vh"

module cod_decode (
    // opcode
    input wire [7:0] opcode,
    // decoded fields
    output wire [3:0] opClass,
    output wire [3:0] addrMode,
    output wire idxY,
    output wire legal
);

// result is {legal, idxY, mode, class}
function [9:0] decode;
    input [7:0] op;
    begin
        case (op)
            8'h49: decode = {2'b10, `COD_M_IMM, `COD_C_XOR};
            8'h45: decode = {2'b10, `COD_M_ZP, `COD_C_XOR};
            8'h55: decode = {2'b10, `COD_M_ZPI, `COD_C_XOR};
            8'h4D: decode = {2'b10, `COD_M_ABS, `COD_C_XOR};
            8'h5D: decode = {2'b10, `COD_M_ABSI, `COD_C_XOR};
            8'h59: decode = {2'b11, `COD_M_ABSI, `COD_C_XOR};
            8'h41: decode = {2'b10, `COD_M_INDX, `COD_C_XOR};
            8'h51: decode = {2'b11, `COD_M_INDY, `COD_C_XOR};
            8'hE6: decode = {2'b10, `COD_M_ZP, `COD_C_INCM};
            8'hF6: decode = {2'b10, `COD_M_ZPI, `COD_C_INCM};
            8'hEE: decode = {2'b10, `COD_M_ABS, `COD_C_INCM};
            8'hFE: decode = {2'b10, `COD_M_ABSI, `COD_C_INCM};
            8'hE8: decode = {2'b10, `COD_M_IMP, `COD_C_INCX};
            8'hC8: decode = {2'b10, `COD_M_IMP, `COD_C_INCY};
            8'h4C: decode = {2'b10, `COD_M_ABS, `COD_C_JUMP};
            8'h6C: decode = {2'b10, `COD_M_IND, `COD_C_JUMP};
            8'h20: decode = {2'b10, `COD_M_ABS, `COD_C_CALL};
            8'hA9: decode = {2'b10, `COD_M_IMM, `COD_C_LOADA};
            8'hA5: decode = {2'b10, `COD_M_ZP, `COD_C_LOADA};
            8'hB5: decode = {2'b10, `COD_M_ZPI, `COD_C_LOADA};
            8'hAD: decode = {2'b10, `COD_M_ABS, `COD_C_LOADA};
            8'hBD: decode = {2'b10, `COD_M_ABSI, `COD_C_LOADA};
            8'hB9: decode = {2'b11, `COD_M_ABSI, `COD_C_LOADA};
            8'hA1: decode = {2'b10, `COD_M_INDX, `COD_C_LOADA};
            8'hB1: decode = {2'b11, `COD_M_INDY, `COD_C_LOADA};
            8'hA2: decode = {2'b10, `COD_M_IMM, `COD_C_LOADX};
            8'hA6: decode = {2'b10, `COD_M_ZP, `COD_C_LOADX};
            8'hB6: decode = {2'b11, `COD_M_ZPI, `COD_C_LOADX};
            8'hAE: decode = {2'b10, `COD_M_ABS, `COD_C_LOADX};
            8'hBE: decode = {2'b11, `COD_M_ABSI, `COD_C_LOADX};
            8'hA0: decode = {2'b10, `COD_M_IMM, `COD_C_LOADY};
            8'hA4: decode = {2'b10, `COD_M_ZP, `COD_C_LOADY};
            8'hB4: decode = {2'b10, `COD_M_ZPI, `COD_C_LOADY};
            8'hAC: decode = {2'b10, `COD_M_ABS, `COD_C_LOADY};
            8'hBC: decode = {2'b10, `COD_M_ABSI, `COD_C_LOADY};
            8'h4A: decode = {2'b10, `COD_M_ACC, `COD_C_SHR};
            8'h46: decode = {2'b10, `COD_M_ZP, `COD_C_SHR};
            8'h56: decode = {2'b10, `COD_M_ZPI, `COD_C_SHR};
            8'h4E: decode = {2'b10, `COD_M_ABS, `COD_C_SHR};
            8'h5E: decode = {2'b10, `COD_M_ABSI, `COD_C_SHR};
            8'hEA: decode = {2'b10, `COD_M_IMP, `COD_C_IDLE};
            8'h09: decode = {2'b10, `COD_M_IMM, `COD_C_OR};
            8'h05: decode = {2'b10, `COD_M_ZP, `COD_C_OR};
            8'h15: decode = {2'b10, `COD_M_ZPI, `COD_C_OR};
            8'h0D: decode = {2'b10, `COD_M_ABS, `COD_C_OR};
            8'h1D: decode = {2'b10, `COD_M_ABSI, `COD_C_OR};
            8'h19: decode = {2'b11, `COD_M_ABSI, `COD_C_OR};
            8'h01: decode = {2'b10, `COD_M_INDX, `COD_C_OR};
            8'h11: decode = {2'b11, `COD_M_INDY, `COD_C_OR};
            8'h48: decode = {2'b10, `COD_M_IMP, `COD_C_PUSHA};
            8'h08: decode = {2'b10, `COD_M_IMP, `COD_C_PUSHP};
            // outside this slice: run as a two-cycle idle and flag it
            default: decode = {2'b00, `COD_M_IMP, `COD_C_IDLE};
        endcase
    end
endfunction

wire [9:0] fields;
assign fields = decode(opcode);
assign opClass = fields[3:0];
assign addrMode = fields[7:4];
assign idxY = fields[8];
assign legal = fields[9];

endmodule // cod_decode

// ---- hw/cod_alu.v ----
// data path: logic, load, increment and right shift results with flags
`timescale 1ns/1ps
`include "cod_defines.vh"

module cod_alu (
    // operation
    input wire [3:0] opClass,
    input wire accMode,
    // operands
    input wire [7:0] accIn,
    input wire [7:0] xIn,
    input wire [7:0] yIn,
    input wire [7:0] memIn,
    // results
    output reg [7:0] result,
    output wire negOut,
    output wire zeroOut,
    output reg carryOut
);

reg [7:0] shSrc;

always @* begin
    shSrc = accMode ? accIn : memIn;
    carryOut = 1'b0;
    case (opClass)
        `COD_C_XOR: result = accIn ^ memIn;
        `COD_C_OR: result = accIn | memIn;
        `COD_C_INCM: result = memIn + 8'h01;
        `COD_C_INCX: result = xIn + 8'h01;
        `COD_C_INCY: result = yIn + 8'h01;
        `COD_C_SHR: begin
            result = {1'b0, shSrc[7:1]};
            carryOut = shSrc[0];
        end
        default: result = memIn;
    endcase
end

// a zero shifted in keeps negative clear after a right shift
assign negOut = result[7];
assign zeroOut = (result == 8'h00);

endmodule // cod_alu

// ---- tb/cod_mem_model.sv ----
// behavioural memory on the core bus: async read, write at the clock edge
`timescale 1ns/1ps
module cod_mem_model (
    // clock
    input logic clk,
    // bus from the core
    input logic [15:0] memAddr,
    input logic [7:0] memWdata,
    input logic memWe,
    // read data
    output logic [7:0] memRdata
);
    logic [7:0] mem [0:65535];
    // undriven in write cycles: show a wrong value
    assign memRdata = memWe ? ~mem[memAddr] : mem[memAddr];
    always @(posedge clk) if (memWe) mem[memAddr] <= memWdata;
endmodule // cod_mem_model

// ---- tb/cod_core_asserts.sv ----
// concurrent checks on the cpu slice core ports
`timescale 1ns/1ps
module cod_core_asserts (
    // clock and reset
    input logic clk,
    input logic rstn,
    // memory bus
    input logic [15:0] memAddr,
    input logic [7:0] memRdata,
    input logic [7:0] memWdata,
    input logic memWe,
    // progress and state
    input logic instrStart,
    input logic illegalOp,
    input logic [3:0] lastCycles,
    input logic [15:0] pcOut,
    input logic [7:0] accOut,
    input logic [7:0] xOut,
    input logic [7:0] yOut,
    input logic [7:0] spOut,
    input logic [7:0] statusOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [15:0] startPc_r;
    logic [15:0] retAddr;
    logic accLsb;
    assign retAddr = startPc_r + 16'h0002;
    assign accLsb = accOut[0];
    // pc may advance mid-call, so keep the opcode address
    always @(posedge clk) if (instrStart) startPc_r <= memAddr;
    a_reset_state: assert property (disable iff (1'b0) !rstn |=> pcOut == 16'h0000
        && spOut == 8'hFF && instrStart && !memWe && statusOut == 8'h34)
        else $error("state after reset wrong");
    a_fetch_pc: assert property (instrStart |-> memAddr == pcOut && !memWe)
        else $error("fetch not at pc");
    a_illegal_pulse: assert property (illegalOp |-> instrStart && !$past(instrStart)
        && $past(instrStart, 2) ##1 !instrStart && !illegalOp)
        else $error("illegal pulse wrong");
    a_nop_quiet: assert property (instrStart && memRdata == 8'hEA |=> !instrStart
        ##1 instrStart && pcOut == $past(pcOut, 2) + 16'h0001 && accOut == $past(accOut, 2)
        && statusOut == $past(statusOut, 2) && $stable(xOut) && $stable(yOut))
        else $error("no-op changed state");
    a_incx_flags: assert property (instrStart && memRdata == 8'hE8 |=> ##1 instrStart
        && xOut == $past(xOut, 2) + 8'h01 && statusOut[7] == xOut[7]
        && statusOut[1] == (xOut == 8'h00))
        else $error("index increment wrong");
    a_jump_abs: assert property (instrStart && memRdata == 8'h4C |=> ##2 instrStart
        && pcOut == {$past(memRdata, 1), $past(memRdata, 2)})
        else $error("jump target wrong");
    a_call_push: assert property (instrStart && memRdata == 8'h20 |=> ##2 memWe
        && memAddr == {8'h01, spOut} && memWdata == retAddr[15:8] ##1 memWe
        && memWdata == retAddr[7:0] ##2 instrStart
        && pcOut == {$past(memRdata, 1), $past(memRdata, 5)})
        else $error("call sequence wrong");
    a_push_acc: assert property (instrStart && memRdata == 8'h48 |=> ##1 memWe
        && memAddr == {8'h01, spOut} && memWdata == accOut
        ##1 instrStart && spOut == $past(spOut) - 8'h01)
        else $error("accumulator push wrong");
    a_push_status: assert property (instrStart && memRdata == 8'h08 |=> ##1 memWe
        && memWdata == statusOut ##1 instrStart && $stable(statusOut))
        else $error("status push wrong");
    a_shift_acc: assert property (instrStart && memRdata == 8'h4A |=> ##1 instrStart
        && accOut == ($past(accOut, 2) >> 1) && statusOut[0] == $past(accLsb, 2)
        && !statusOut[7])
        else $error("right shift wrong");
    a_incm_long: assert property (instrStart && memRdata == 8'hFE
        |=> !instrStart [*6] ##1 instrStart)
        else $error("indexed increment length wrong");
    c_call: cover property (instrStart && memRdata == 8'h20);
    c_illegal: cover property (illegalOp);
    c_stack_write: cover property (memWe && memAddr[15:8] == 8'h01);
endmodule // cod_core_asserts
bind cod_core cod_core_asserts i_cod_core_asserts (.clk(clk), .rstn(rstn),
    .memAddr(memAddr), .memRdata(memRdata), .memWdata(memWdata), .memWe(memWe),
    .instrStart(instrStart), .illegalOp(illegalOp), .lastCycles(lastCycles),
    .pcOut(pcOut), .accOut(accOut), .xOut(xOut), .yOut(yOut), .spOut(spOut),
    .statusOut(statusOut));

// ---- tb/tb_top.sv ----
// random program bench with an instruction-level model compared per instruction
`timescale 1ns/1ps
module tb_top;
    localparam [255:0] OPS = 256'h494D5D51E6FEEEF6E8C84C6C20A9ADBDB1A2B6BEA0BC4A5E41EA090D194808FF;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    wire [15:0] memAddr, pcOut;
    wire [7:0] memRdata, memWdata, accOut, xOut, yOut, spOut, statusOut;
    wire memWe, instrStart, illegalOp;
    wire [3:0] lastCycles;
    integer failures = 0;
    integer check_count = 0;
    reg [31:0] rnd = 32'h0A50;
    reg [7:0] im [0:65535];
    reg [23:0] wq [$];
    integer pc, a, x, y, sp, n, z, c, cy, nIns, cyc;
    reg illNext, done;
    always #2 clk = ~clk;
    cod_core i_cod_core (.clk(clk), .rstn(rstn), .memAddr(memAddr), .memRdata(memRdata),
        .memWdata(memWdata), .memWe(memWe), .instrStart(instrStart), .illegalOp(illegalOp),
        .lastCycles(lastCycles), .pcOut(pcOut), .accOut(accOut), .xOut(xOut), .yOut(yOut),
        .spOut(spOut), .statusOut(statusOut));
    cod_mem_model i_cod_mem_model (.clk(clk), .memAddr(memAddr), .memWdata(memWdata),
        .memWe(memWe), .memRdata(memRdata));
    function [31:0] lfsr(input [31:0] s);
        lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    function integer rd(input integer ad);
        rd = im[ad & 16'hFFFF];
    endfunction
    task chk(input string name, input [15:0] seen, input [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("FAIL %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_sim;
        if (failures == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input integer ad, input integer v);
        wq.push_back({ad[15:0], v[7:0]});
        im[ad] = v;
    endtask
    task nz(input integer r);
        n = (r >> 7) & 1;
        z = (r == 0);
    endtask
    task step;
        integer op, g, aa, bb, lo, hi, ea, e0, i, v, r, ln;
        op = rd(pc); g = op & 3; aa = op >> 5; bb = (op >> 2) & 7;
        lo = rd(pc + 1); hi = rd(pc + 2); cy = 2; ln = 1; ea = -1;
        illNext = (op == 8'hFF);
        case (op)
            8'hE8: begin x = (x + 1) & 255; nz(x); end
            8'hC8: begin y = (y + 1) & 255; nz(y); end
            8'hEA, 8'hFF: ;
            8'h48: begin wr(256 + sp, a); sp = (sp - 1) & 255; cy = 3; end
            8'h08: begin wr(256 + sp, (n << 7) | 8'h34 | (z << 1) | c); sp = (sp - 1) & 255; cy = 3; end
            8'h20: begin
                r = pc + 2; wr(256 + sp, r >> 8); sp = (sp - 1) & 255;
                wr(256 + sp, r & 255); sp = (sp - 1) & 255; cy = 6; ln = 0; pc = hi * 256 + lo;
            end
            8'h4C: begin cy = 3; ln = 0; pc = hi * 256 + lo; end
            8'h6C: begin cy = 5; ln = 0; e0 = hi * 256 + lo; pc = rd(e0) + 256 * rd(e0 + 1); end
            default: begin
                i = (g == 2 && aa == 5) ? y : x;
                ln = 2;
                case (bb)
                    0: if (g == 1) begin
                        e0 = (lo + x) & 255; ea = rd(e0) + 256 * rd((e0 + 1) & 255); cy = 6;
                    end else ea = pc + 1;
                    1: begin ea = lo; cy = 3; end
                    2: if (g == 1) ea = pc + 1; else ln = 1;
                    3: begin ea = hi * 256 + lo; cy = 4; ln = 3; end
                    4: begin
                        e0 = rd(lo) + 256 * rd((lo + 1) & 255); ea = (e0 + y) & 16'hFFFF;
                        cy = 5 + ((e0 & 255) + y > 255);
                    end
                    5: begin ea = (lo + i) & 255; cy = 4; end
                    default: begin
                        i = (bb == 6) ? y : i; ea = (hi * 256 + lo + i) & 16'hFFFF;
                        cy = 4 + (lo + i > 255); ln = 3;
                    end
                endcase
                v = (ea < 0) ? a : rd(ea);
                if (g == 2 && aa != 5 && ea >= 0) cy = (bb == 7) ? 7 : cy + 2;
                if (g == 1) begin
                    a = (aa == 0) ? (a | v) : (aa == 2) ? (a ^ v) : v; nz(a);
                end else if (aa == 5) begin
                    if (g == 2) x = v; else y = v;
                    nz(v);
                end else begin
                    r = (aa == 7) ? ((v + 1) & 255) : (v >> 1);
                    if (aa == 2) c = v & 1;
                    nz(r);
                    if (ea < 0) a = r; else begin wr(ea, v); wr(ea, r); end
                end
            end
        endcase
        pc = (pc + ln) & 16'hFFFF;
    endtask
    initial begin
        integer k, ad, op, bb, t;
        for (k = 0; k < 65536; k = k + 1) begin rnd = lfsr(rnd); im[k] = rnd[7:0]; end
        im[0] = 8'h4C; im[1] = 8'h00; im[2] = 8'h02; ad = 16'h0200;
        for (k = 0; k < 150; k = k + 1) begin
            rnd = lfsr(rnd); op = OPS[8 * rnd[12:8] +: 8]; bb = (op >> 2) & 7; im[ad] = op;
            t = ((op & 3) == 3) ? 1 : (op == 8'h20 || bb == 3 || bb >= 6) ? 3
                : (bb == 2 && (op & 3) != 1) ? 1 : 2;
            // abs writes kept in 3000-38FF, away from code and pointers
            if (t == 3) im[ad + 2] = 8'h30 + rnd[2:0];
            if (op == 8'h20 || op == 8'h4C) begin im[ad + 1] = (ad + 3) & 255; im[ad + 2] = (ad + 3) >> 8; end
            if (op == 8'h6C) begin
                im[ad + 1] = (2 * k) & 255; im[ad + 2] = 8'h40 + (2 * k >> 8);
                im[16'h4000 + 2 * k] = (ad + 3) & 255; im[16'h4001 + 2 * k] = (ad + 3) >> 8;
            end
            ad = ad + t;
        end
        for (k = 0; k < 65536; k = k + 1) i_cod_mem_model.mem[k] = im[k];
        pc = 0; a = 0; x = 0; y = 0; sp = 255; n = 0; z = 0; c = 0; cy = 0;
        nIns = 0; illNext = 1'b0; done = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        for (cyc = 0; cyc < 4000 && !done; cyc = cyc + 1) begin
            chk("illegalOp", illegalOp, illNext && instrStart === 1'b1);
            if (memWe === 1'b1) begin
                if (wq.size() == 0) chk("memWe", memWe, 1'b0);
                else begin
                    chk("memAddr", memAddr, wq[0][23:8]);
                    chk("memWdata", memWdata, wq[0][7:0]);
                    wq.pop_front();
                end
            end
            if (instrStart === 1'b1) begin
                chk("pcOut", pcOut, pc);
                chk("accOut", accOut, a);
                chk("xOut", xOut, x);
                chk("yOut", yOut, y);
                chk("spOut", spOut, sp);
                chk("statusOut", statusOut, (n << 7) | 8'h34 | (z << 1) | c);
                chk("lastCycles", lastCycles, cy);
                chk("pendingWrites", wq.size(), 0);
                if (nIns < 151) begin nIns = nIns + 1; step; end
                else done = 1'b1;
            end
            if (!done) @(negedge clk);
        end
        chk("finished", done, 1'b1);
        end_sim;
    end
endmodule // tb_top
